// File: testbench/spx_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module spx_link_sva
	import spx_pkg::*;
(
	// System
	input wire logic clock_i,
	input wire logic resetn_i,
	// Link
	input wire logic system_clear_n,
	input wire logic select_n,
	input wire logic sclk,
	input wire logic sdata_to_dev,
	input wire logic sdata_from_dev
);
	// --------------------------------
	// Frame counters
	// --------------------------------
	// Clockless setup needs 200 ns of select low at 10 ns a cycle
	localparam int MIN_LOW = SEL_LOW_CYCLES;
	logic       sclk_q;
	logic [4:0] rises;
	logic [7:0] low_cycles;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);

	always_ff @(posedge clock_i) begin
		sclk_q <= resetn_i & sclk;
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i || select_n) begin
			rises <= 5'h00;
		end else if (sclk && !sclk_q) begin
			rises <= rises + 5'h01;
		end
	end

	// Saturates so a long setup pulse never wraps below the bound
	always_ff @(posedge clock_i) begin
		if (!resetn_i || select_n) begin
			low_cycles <= 8'h00;
		end else if (low_cycles != 8'hFF) begin
			low_cycles <= low_cycles + 8'h01;
		end
	end

	// --------------------------------
	// Link rules
	// --------------------------------
	clear_out_high_a: assert property (!system_clear_n [*8] |-> sdata_from_dev)
		else $error("serial out not high during clear");
	clear_width_a: assert property ($fell(system_clear_n) |=> !system_clear_n [*8])
		else $error("clear pulse too short");
	frame_start_a: assert property ($fell(select_n) |-> system_clear_n && !sclk)
		else $error("frame opened during clear or with clock high");
	frame_bits_a: assert property ($rose(select_n) |-> rises == 5'h00 || rises == FRAME_BITS)
		else $error("frame closed with a partial word");
	bit_limit_a: assert property (!select_n |-> rises <= FRAME_BITS)
		else $error("more clock rises than one word");
	setup_width_a: assert property ($rose(select_n) && rises == 5'h00 |-> low_cycles >= MIN_LOW)
		else $error("clockless select pulse too short");
	data_stable_a: assert property (sclk && $past(sclk) |-> $stable(sdata_to_dev))
		else $error("serial data moved while clock high");
	sclk_high_a: assert property ($rose(sclk) |=> sclk [*5])
		else $error("serial clock high phase too short");

	full_frame_c: cover property ($rose(select_n) && rises == FRAME_BITS);
	setup_pulse_c: cover property ($rose(select_n) && rises == 5'h00);
	clear_pulse_c: cover property ($fell(system_clear_n));
endmodule : spx_link_sva
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import spx_pkg::*;

	typedef struct packed {
		logic [23:0] word;
		logic [23:0] ext;
		logic [23:0] rx;
		logic [23:0] oe;
		logic [23:0] hi;
	} spx_row_s;

	// --------------------------------
	// Signals
	// --------------------------------
	logic        clock_i     = 1'b0;
	logic        resetn_i    = 1'b0;
	logic        clear_req   = 1'b0;
	logic        setup_pulse = 1'b0;
	logic [23:0] tx_data     = 24'h00_0000;
	logic        tx_valid    = 1'b0;
	logic        tx_ready;
	logic [23:0] rx_data;
	logic        rx_valid;
	logic        busy;
	logic [23:0] ext         = 24'h00_0000;
	logic [23:0] pins_i;
	logic [23:0] pins_o;
	logic [23:0] pins_oe;
	logic        data_mode;
	logic [23:0] f_ext       = 24'h5A_C3E1;
	logic [23:0] f_pins;
	logic [23:0] f_o;
	logic [23:0] f_oe;
	logic        f_mode;
	logic [23:0] f_cap;
	logic [23:0] got;
	int          fail_count  = 0;
	int          checks      = 0;
	int          rx_seen     = 0;
	int          n_acc;
	// Word sent, pad levels, expected readback, enables, driven-high pins
	spx_row_s    rows [3]    = '{
		'{24'h0F_0F0F, 24'hA5_5AA5, 24'hA5_FFA5, 24'hF0_FFF0, 24'h00_0F00},
		'{24'hFF_FFFF, 24'h3C_C33C, 24'hFC_FFFC, 24'h00_FF00, 24'h00_FF00},
		'{24'h00_0000, 24'h0F_F0F0, 24'h0F_FFF0, 24'hFF_FFFF, 24'h00_0000}
	};

	spx_link_if link_if ();
	spx_link_if fault_if ();

	// Pads read what is driven, else the outside level
	assign pins_i = (pins_oe & pins_o) | (~pins_oe & ext);
	assign f_pins = (f_oe & f_o) | (~f_oe & f_ext);

	always #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;

	always @(posedge clock_i) begin
		if (rx_valid === 1'b1) begin
			rx_seen++;
		end
	end

	spx_host spx_host_inst (
		.clock_i       (clock_i),
		.resetn_i      (resetn_i),
		.link          (link_if),
		.clear_req_i   (clear_req),
		.setup_pulse_i (setup_pulse),
		.tx_data_i     (tx_data),
		.tx_valid_i    (tx_valid),
		.tx_ready_o    (tx_ready),
		.rx_data_o     (rx_data),
		.rx_valid_o    (rx_valid),
		.busy_o        (busy)
	);

	spx_device spx_device_inst (
		.clock_i            (clock_i),
		.resetn_i           (resetn_i),
		.link               (link_if),
		.expander_pins_i    (pins_i),
		.expander_pins_o    (pins_o),
		.expander_pins_oe_o (pins_oe),
		.data_mode_o        (data_mode)
	);

	// Second device on a link driven by the bench, for misbehaving hosts
	spx_device spx_device_fault_inst (
		.clock_i            (clock_i),
		.resetn_i           (resetn_i),
		.link               (fault_if),
		.expander_pins_i    (f_pins),
		.expander_pins_o    (f_o),
		.expander_pins_oe_o (f_oe),
		.data_mode_o        (f_mode)
	);

	spx_link_sva spx_link_sva_inst (
		.clock_i        (clock_i),
		.resetn_i       (resetn_i),
		.system_clear_n (link_if.system_clear_n),
		.select_n       (link_if.select_n),
		.sclk           (link_if.sclk),
		.sdata_to_dev   (link_if.sdata_to_dev),
		.sdata_from_dev (link_if.sdata_from_dev)
	);

	// --------------------------------
	// Tasks
	// --------------------------------
	task give_verdict;
		if (fail_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	task check_word(input string name, input logic [23:0] exp, input logic [23:0] seen);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check_word

	task check_bit(input string name, input logic exp, input logic seen);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %b seen %b", name, exp, seen);
		end
	endtask : check_bit

	task cycles(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : cycles

	task push(input logic [23:0] w);
		int n;
		n = 0;
		tx_data = w;
		tx_valid = 1'b1;
		do begin
			@(posedge clock_i);
			n++;
		end while (tx_ready !== 1'b1 && n < 100);
		check_bit("word accepted", 1'b1, tx_ready);
		#1;
		tx_valid = 1'b0;
	endtask : push

	task wait_rx;
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			#1;
			n++;
		end while (rx_valid !== 1'b1 && n < 3000);
		got = rx_data;
		check_bit("frame delivered", 1'b1, rx_valid);
	endtask : wait_rx

	// Reads the serial output half a clock after each fall
	task f_bit(input logic b);
		fault_if.sdata_to_dev = b;
		#62.5;
		f_cap = {fault_if.sdata_from_dev, f_cap[23:1]};
		fault_if.sclk = 1'b1;
		#62.5;
		fault_if.sclk = 1'b0;
	endtask : f_bit

	task f_frame(input logic [23:0] w, input int n);
		fault_if.select_n = 1'b0;
		#100;
		for (int k = 0; k < n; k++) begin
			f_bit(w[k]);
		end
		#62.5;
		f_cap = {fault_if.sdata_from_dev, f_cap[23:1]};
		#100;
		fault_if.select_n = 1'b1;
		#300;
	endtask : f_frame

	// About four times the expected run
	initial begin
		#400000;
		fail_count++;
		give_verdict();
	end

	// --------------------------------
	// Sequence
	// --------------------------------
	initial begin
		fault_if.system_clear_n = 1'b0;
		fault_if.select_n = 1'b1;
		fault_if.sclk = 1'b0;
		fault_if.sdata_to_dev = 1'b0;
		repeat (16) @(posedge clock_i);
		#1;
		resetn_i = 1'b1;
		cycles(8);
		check_word("pin enables", 24'h00_0000, pins_oe);
		check_bit("data mode", 1'b0, data_mode);
		check_bit("serial out", 1'b1, link_if.sdata_from_dev);
		cycles(40);
		ext = 24'h12_3456;
		push(24'h00_FF00);
		wait_rx();
		check_word("setup readback", 24'h12_3456, got);
		cycles(20);
		check_bit("data mode", 1'b1, data_mode);
		foreach (rows[i]) begin
			ext = rows[i].ext;
			push(rows[i].word);
			wait_rx();
			check_word("readback", rows[i].rx, got);
			cycles(20);
			check_word("pin enables", rows[i].oe, pins_oe);
			check_word("pin levels", rows[i].hi, pins_o & pins_oe);
		end
		// Fill the host buffer until it refuses, then let it drain
		rx_seen = 0;
		n_acc = 0;
		tx_valid = 1'b1;
		do begin
			@(posedge clock_i);
			if (tx_ready === 1'b1) begin
				n_acc++;
			end
		end while (tx_ready === 1'b1 && n_acc < 20);
		#1;
		tx_valid = 1'b0;
		check_bit("buffer refused", 1'b1, n_acc >= 16 && n_acc <= 17);
		for (int n = 0; n < 9000 && rx_seen < n_acc; n++) begin
			@(posedge clock_i);
		end
		cycles(400);
		check_word("drained frames", 24'(n_acc), 24'(rx_seen));
		check_bit("host busy", 1'b0, busy);
		clear_req = 1'b1;
		cycles(1);
		clear_req = 1'b0;
		cycles(60);
		check_word("pin enables", 24'h00_0000, pins_oe);
		check_bit("data mode", 1'b0, data_mode);
		setup_pulse = 1'b1;
		cycles(1);
		setup_pulse = 1'b0;
		cycles(60);
		check_bit("data mode", 1'b1, data_mode);
		check_word("pin enables", 24'h00_0000, pins_oe);
		check_bit("fault serial out", 1'b1, fault_if.sdata_from_dev);
		fault_if.system_clear_n = 1'b1;
		#200;
		f_frame(24'hFF_FFFF, 10);
		check_bit("short frame mode", 1'b0, f_mode);
		check_word("short frame pins", 24'h00_0000, f_oe);
		fault_if.select_n = 1'b0;
		#250;
		fault_if.select_n = 1'b1;
		#300;
		check_bit("clockless mode", 1'b1, f_mode);
		f_frame(24'hFF_00FF, 24);
		check_word("serial bit order", f_ext, f_cap);
		check_word("fault pin enables", 24'h00_FF00, f_oe);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire

// File: verilog/spx_device.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Clear low resets logic, output high, pins hi-Z
// - Reset direction zero, output state one
// - Pin drive follows direction and output bits
// - Non-input pins read back as high
// - Clockless select pulse fixes direction zero
// - Transfers happen only while select low
// - First falling edge passes live pin zero
// - Next rising edge captures remaining 23 pins
// - Later falling edges shift pins out in order
// - Host bits sampled on rising edges, pin order
// - First full frame loads direction register
// - Data frames load output state, update pins
// - Every full data frame samples and refreshes
// - Chained devices need 24 bits each
// - Host holds clockless select low 200 ns
// - First bit follows live pin level
module spx_device
	import spx_pkg::*;
(
	// System
	input  wire logic                 clock_i,
	input  wire logic                 resetn_i,
	// Link
	spx_link_if.dev                   link,
	// Expander pins
	input  wire logic [PIN_COUNT-1:0] expander_pins_i,
	output var  logic [PIN_COUNT-1:0] expander_pins_o,
	output var  logic [PIN_COUNT-1:0] expander_pins_oe_o,
	// Status
	output var  logic                 data_mode_o
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [2:0] clr_sync;
	logic [2:0] sel_sync;
	logic [2:0] clk_sync;
	logic [2:0] din_sync;
	logic       clr_n_q;
	logic       sel_n_q;
	logic       sclk_q;
	logic       din_q;

	always_ff @(posedge clock_i) begin
		clr_sync <= {clr_sync[1:0], link.system_clear_n};
		sel_sync <= {sel_sync[1:0], link.select_n};
		clk_sync <= {clk_sync[1:0], link.sclk};
		din_sync <= {din_sync[1:0], link.sdata_to_dev};
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			clr_n_q <= 1'b0;
			sel_n_q <= 1'b1;
			sclk_q  <= 1'b0;
			din_q   <= 1'b0;
		end else begin
			if (clr_sync[1] == clr_sync[2]) begin
				clr_n_q <= clr_sync[2];
			end
			if (sel_sync[1] == sel_sync[2]) begin
				sel_n_q <= sel_sync[2];
			end
			if (clk_sync[1] == clk_sync[2]) begin
				sclk_q <= clk_sync[2];
			end
			if (din_sync[1] == din_sync[2]) begin
				din_q <= din_sync[2];
			end
		end
	end

	// Pins are asynchronous; a bit moves once stages two and three agree
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_mid;
	logic [PIN_COUNT-1:0] pin_late;
	logic [PIN_COUNT-1:0] pin_live;
	always_ff @(posedge clock_i) begin
		pin_meta <= expander_pins_i;
		pin_mid  <= pin_meta;
		pin_late <= pin_mid;
	end

	always_ff @(posedge clock_i) begin
		pin_live <= (pin_mid & pin_late) | (pin_live & (pin_mid ^ pin_late));
	end

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	logic sclk_d;
	logic sel_n_d;
	logic clear_now;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_fall;
	logic sel_rise;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			sclk_d  <= 1'b0;
			sel_n_d <= 1'b1;
		end else begin
			sclk_d  <= sclk_q;
			sel_n_d <= sel_n_q;
		end
	end

	assign clear_now = !resetn_i || !clr_n_q;
	assign sclk_rise = !sel_n_q && sclk_q && !sclk_d;
	assign sclk_fall = !sel_n_q && !sclk_q && sclk_d;
	assign sel_fall  = !sel_n_q && sel_n_d;
	assign sel_rise  = sel_n_q && !sel_n_d;

	// ------------------------------------------------------------
	// Frame state
	// ------------------------------------------------------------
	logic [CNT_W-1:0]     rise_cnt;
	logic                 fell_once;
	logic                 pins_taken;
	logic [PIN_COUNT-1:0] in_shift;
	logic [PIN_COUNT-1:0] rx_shift;
	spx_mode_e            mode;
	logic [PIN_COUNT-1:0] port_direction_type;
	logic [PIN_COUNT-1:0] port_output_state;
	logic                 frame_full;
	logic [PIN_COUNT-1:0] pin_readback;

	assign pin_readback = pin_live | port_direction_type | ~port_output_state;
	// full frame needs the 24th rising edge
	assign frame_full   = (rise_cnt >= FRAME_BITS);

	always_ff @(posedge clock_i) begin
		if (clear_now || sel_fall) begin
			rise_cnt   <= '0;
			fell_once  <= 1'b0;
			pins_taken <= 1'b0;
		end else begin
			if (sclk_rise && !frame_full) begin
				rise_cnt <= rise_cnt + 1'b1;
			end
			if (sclk_fall) begin
				fell_once <= 1'b1;
			end
			if (sclk_rise && fell_once) begin
				pins_taken <= 1'b1;
			end
		end
	end

	// capture remaining pins on first rise after a fall
	// shift captured bits out, pin 1 first
	always_ff @(posedge clock_i) begin
		if (clear_now) begin
			in_shift <= '1;
		// Link clock idles low: the capture rise is the first after a fall
		end else if (sclk_rise && fell_once && !pins_taken) begin
			in_shift <= {1'b1, pin_readback[PIN_COUNT-1:1]};
		end else if (sclk_fall && fell_once) begin
			in_shift <= {1'b1, in_shift[PIN_COUNT-1:1]};
		end
	end

	// host bits enter in pin order, lowest pin first
	always_ff @(posedge clock_i) begin
		if (clear_now) begin
			rx_shift <= '0;
		end else if (sclk_rise) begin
			rx_shift <= {din_q, rx_shift[PIN_COUNT-1:1]};
		end
	end

	// first bit is the live pin 0 level
	// first bit tracks the pin until the capture rise
	always_ff @(posedge clock_i) begin
		if (clear_now) begin
			link.sdata_from_dev <= 1'b1;
		end else if (sclk_fall && !fell_once) begin
			link.sdata_from_dev <= pin_readback[0];
		end else if (!sel_n_q && fell_once && !pins_taken) begin
			link.sdata_from_dev <= pin_readback[0];
		end else if (sclk_fall) begin
			link.sdata_from_dev <= in_shift[0];
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// reset values
	// no clock edges selects simplified setup
	always_ff @(posedge clock_i) begin
		if (clear_now) begin
			mode                <= SPX_MODE_INIT;
			port_direction_type <= DIR_RESET;
		end else if (sel_rise && mode == SPX_MODE_INIT) begin
			if (rise_cnt == '0 && !fell_once) begin
				mode <= SPX_MODE_DATA;
			end else if (frame_full) begin
				port_direction_type <= rx_shift;
				mode                <= SPX_MODE_DATA;
			end
		end
	end

	// every full data frame refreshes the pins
	// chained frames keep only the last 24 bits
	always_ff @(posedge clock_i) begin
		if (clear_now) begin
			port_output_state <= OUT_RESET;
		end else if (sel_rise && mode == SPX_MODE_DATA && frame_full) begin
			port_output_state <= rx_shift;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// drive from direction and output bits
	always_ff @(posedge clock_i) begin
		if (clear_now) begin
			expander_pins_o    <= '0;
			expander_pins_oe_o <= '0;
			data_mode_o        <= 1'b0;
		end else begin
			expander_pins_o    <= port_output_state & port_direction_type;
			expander_pins_oe_o <= port_direction_type | ~port_output_state;
			data_mode_o        <= (mode == SPX_MODE_DATA);
		end
	end
endmodule : spx_device
`default_nettype wire

// File: verilog/spx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module spx_fifo #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 16
) (
	// System
	input  wire logic             clock_i,
	input  wire logic             resetn_i,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output var  logic             in_ready_o,
	// Drain side
	output var  logic [WIDTH-1:0] out_data_o,
	output var  logic             out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : spx_fifo
`default_nettype wire

// File: verilog/spx_host.sv
`timescale 1ns/10ps
`default_nettype none
module spx_host
	import spx_pkg::*;
(
	// System
	input  wire logic                 clock_i,
	input  wire logic                 resetn_i,
	// Link
	spx_link_if.host                  link,
	// Commands
	input  wire logic                 clear_req_i,
	input  wire logic                 setup_pulse_i,
	// Outgoing words
	input  wire logic [PIN_COUNT-1:0] tx_data_i,
	input  wire logic                 tx_valid_i,
	output var  logic                 tx_ready_o,
	// Received pin levels
	output var  logic [PIN_COUNT-1:0] rx_data_o,
	output var  logic                 rx_valid_o,
	output var  logic                 busy_o
);
	spx_host_e            state;
	logic [3:0]           div_cnt;
	logic                 tick;
	logic [CNT_W-1:0]     bit_cnt;
	logic [7:0]           wait_cnt;
	logic                 pulse_mode;
	logic [PIN_COUNT-1:0] tx_shift;
	logic [PIN_COUNT-1:0] rx_shift;
	logic [2:0]           dout_sync;
	logic                 dout_q;
	logic [PIN_COUNT-1:0] fifo_data;
	logic                 fifo_valid;
	logic                 fifo_ready;
	logic                 fifo_in_ready;

	// Words queue up; sending stalls while the link is busy
	spx_fifo #(.WIDTH(PIN_COUNT), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_i     (clock_i),
		.resetn_i    (resetn_i),
		.in_data_i   (tx_data_i),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_ready)
	);
	assign tx_ready_o = fifo_in_ready;
	assign fifo_ready = (state == SPX_H_IDLE) && !clear_req_i && !setup_pulse_i;

	always_ff @(posedge clock_i) begin
		dout_sync <= {dout_sync[1:0], link.sdata_from_dev};
	end
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			dout_q <= 1'b1;
		end else if (dout_sync[1] == dout_sync[2]) begin
			dout_q <= dout_sync[2];
		end
	end

	assign tick = (div_cnt == HOST_HALF_DIV);
	always_ff @(posedge clock_i) begin
		if (!resetn_i || state == SPX_H_IDLE || tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// Serial clock idles low; device samples on rising edges
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			state               <= SPX_H_IDLE;
			link.system_clear_n <= 1'b0;
			link.select_n       <= 1'b1;
			link.sclk           <= 1'b0;
			link.sdata_to_dev   <= 1'b0;
			bit_cnt             <= '0;
			wait_cnt            <= '0;
			pulse_mode          <= 1'b0;
			tx_shift            <= '0;
			rx_shift            <= '0;
			rx_data_o           <= '0;
			rx_valid_o          <= 1'b0;
			busy_o              <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			unique case (state)
				SPX_H_IDLE: begin
					busy_o              <= 1'b0;
					link.system_clear_n <= 1'b1;
					wait_cnt            <= '0;
					if (clear_req_i) begin
						link.system_clear_n <= 1'b0;
						busy_o              <= 1'b1;
						state               <= SPX_H_RESET;
					end else if (setup_pulse_i) begin
						link.select_n <= 1'b0;
						pulse_mode    <= 1'b1;
						busy_o        <= 1'b1;
						state         <= SPX_H_SEL;
					end else if (fifo_valid) begin
						link.select_n <= 1'b0;
						// bit 0 settles before the first rise
						link.sdata_to_dev <= fifo_data[0];
						pulse_mode    <= 1'b0;
						tx_shift      <= fifo_data;
						bit_cnt       <= '0;
						busy_o        <= 1'b1;
						state         <= SPX_H_SEL;
					end
				end
				SPX_H_RESET: begin
					wait_cnt <= wait_cnt + 1'b1;
					if (wait_cnt == 8'(SEL_LOW_CYCLES)) begin
						link.system_clear_n <= 1'b1;
						state               <= SPX_H_END;
					end
				end
				SPX_H_SEL: begin
					wait_cnt <= wait_cnt + 1'b1;
					if (pulse_mode && wait_cnt == 8'(SEL_LOW_CYCLES)) begin
						link.select_n <= 1'b1;
						state         <= SPX_H_END;
					end else if (!pulse_mode && tick) begin
						link.sclk         <= 1'b1;
						link.sdata_to_dev <= tx_shift[0];
						state             <= SPX_H_HIGH;
					end
				end
				SPX_H_LOW: begin
					if (tick) begin
						link.sclk <= 1'b1;
						state     <= SPX_H_HIGH;
					end
				end
				SPX_H_HIGH: begin
					if (tick) begin
						link.sclk <= 1'b0;
						state     <= SPX_H_LOW;
						if (bit_cnt == FRAME_BITS - 5'h01) begin
							state <= SPX_H_END;
						end else begin
							bit_cnt           <= bit_cnt + 1'b1;
							tx_shift          <= {1'b0, tx_shift[PIN_COUNT-1:1]};
							link.sdata_to_dev <= tx_shift[1];
						end
						rx_shift <= {dout_q, rx_shift[PIN_COUNT-1:1]};
					end
				end
				// Last bit needs a further half period to cross both synchronisers;
				// select then stays high a half period so the device sees the gap
				SPX_H_END: begin
					if (tick) begin
						if (link.select_n) begin
							state <= SPX_H_IDLE;
						end else if (!pulse_mode && bit_cnt != FRAME_BITS) begin
							bit_cnt <= FRAME_BITS;
						end else begin
							if (!pulse_mode) begin
								rx_data_o  <= {dout_q, rx_shift[PIN_COUNT-1:1]};
								rx_valid_o <= 1'b1;
							end
							link.select_n <= 1'b1;
						end
					end
				end
				default: begin
					state <= SPX_H_IDLE;
				end
			endcase
		end
	end
endmodule : spx_host
`default_nettype wire

// File: verilog/spx_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spx_link_if;
	logic system_clear_n;
	logic select_n;
	logic sclk;
	logic sdata_to_dev;
	logic sdata_from_dev;

	modport dev (
		input  system_clear_n,
		input  select_n,
		input  sclk,
		input  sdata_to_dev,
		output sdata_from_dev
	);
	modport host (
		output system_clear_n,
		output select_n,
		output sclk,
		output sdata_to_dev,
		input  sdata_from_dev
	);
endinterface : spx_link_if
`default_nettype wire

// File: verilog/spx_pkg.sv
`default_nettype none
package spx_pkg;
	localparam int unsigned PIN_COUNT        = 24;
	localparam int unsigned CNT_W            = 5;
	localparam logic [4:0]  FRAME_BITS       = 5'h18;
	localparam logic [23:0] DIR_RESET        = 24'h00_0000;
	localparam logic [23:0] OUT_RESET        = 24'hFF_FFFF;
	localparam int unsigned CLK_PERIOD_NS    = 10;
	// Least select-low width for the clockless setup frame
	localparam int unsigned SEL_LOW_WIDTH_NS = 200;
	localparam int unsigned SEL_LOW_CYCLES   =
		(SEL_LOW_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Host serial clock half period less one, in system clocks
	localparam logic [3:0]  HOST_HALF_DIV    = 4'h6;
	localparam int unsigned FIFO_DEPTH       = 16;

	typedef enum logic [1:0] {
		SPX_MODE_INIT = 2'b00,
		SPX_MODE_DATA = 2'b01
	} spx_mode_e;

	typedef enum logic [2:0] {
		SPX_H_IDLE  = 3'b000,
		SPX_H_RESET = 3'b001,
		SPX_H_SEL   = 3'b010,
		SPX_H_LOW   = 3'b011,
		SPX_H_HIGH  = 3'b100,
		SPX_H_END   = 3'b101
	} spx_host_e;
endpackage : spx_pkg
`default_nettype wire
